// *** rtl/motor_protection_map.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef MOTOR_PROTECTION_MAP_VH
`define MOTOR_PROTECTION_MAP_VH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_OV_LIMIT    8'h10
`define REG_UV_LIMIT    8'h14
`define REG_TEMP_LIMIT  8'h18
`define REG_TO_LIMIT    8'h1C

// ***************************************************************
// control register fields
// ***************************************************************
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_RESTART    2
`define CTRL_TOG_OUT    3
`define CTRL_CUT_HI     4
`define CTRL_CUT_LO     5

// ***************************************************************
// error and interrupt bit positions
// ***************************************************************
`define ERR_OV          0
`define ERR_UV          1
`define ERR_TO          2
`define ERR_TEMP        3
`define IRQ_CUTOFF      4
`define IRQ_STOPPED     5

// ***************************************************************
// reset values: bus voltage in 0.1 V, temperature in degC
// ***************************************************************
`define OV_LIMIT_RST    10'h118
`define UV_LIMIT_RST    10'h096
`define TEMP_LIMIT_RST  8'h41
`define TO_LIMIT_RST    16'h0032

// ***************************************************************
// timing
// ***************************************************************
`define CLK_HZ          100000000
`define LED_TICK_MS     100
`define LED_TICK_CYC    (`CLK_HZ / 1000 * `LED_TICK_MS)
`define MON_PERIOD_MS   1
`define MON_PERIOD_CYC  (`CLK_HZ / 1000 * `MON_PERIOD_MS)
`define BRAKE_MS        200
`define BRAKE_CYC       (`CLK_HZ / 1000 * `BRAKE_MS)
`define GREEN_SLOW_TK   4'h5
`define GREEN_FAST_TK   4'h2
`define RED_HALF_TK     2
`define RED_GAP_TK      10

`endif

// *** rtl/motor_protection_supervisor.v ***
// protection, stop and status indication supervisor for a 3-phase inverter
// Operation
// - entering stop first turns on all three low-side switches to brake.
// - a high overcurrent comparator forces the gates into cut-off at once.
// - once current is low, cut-off ends at the next carrier peak or valley.
// - cut-off gate levels are configurable and default to all gates low.
// - the release is taken from an edge of the carrier toggle signal.
// - the pin shows the carrier toggle when enabled, else it is an input.
// - bus over 28 V at a monitor tick flags overvoltage and stops.
// - bus under 15 V at a monitor tick flags undervoltage and stops.
// - no zero crossing within the timeout flags timeout and stops output.
// - temperature above 65 degC flags a temperature error and stops output.
// - any flagged error moves the system state into STOP.
// - in STOP with no error and no low bus voltage the green lamp is lit steadily.
// - low bus voltage flashes the green lamp with a 1 s period.
// - while running the green lamp flashes with a 0.4 s period.
// - on error the red lamp flashes 0.2 s on and 0.2 s off.
// - flashes per burst: overvoltage 1, undervoltage 2, timeout 4, temp 8.
//
// Implementation choices: the strobed register port and the register addresses.
`include "motor_protection_map.vh"

module motor_protection_supervisor
#(
  parameter LED_TICK_CYC   = `LED_TICK_CYC,
  parameter MON_PERIOD_CYC = `MON_PERIOD_CYC,
  parameter BRAKE_CYC      = `BRAKE_CYC
)
(
  input  wire        clock_in,
  input  wire        arst_n_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_write_in,
  input  wire        reg_read_in,
  output reg  [31:0] reg_rdata_out,
  output reg         irq_out,
  input  wire        overcurrent_in,
  input  wire        zero_cross_in,
  input  wire [9:0]  bus_voltage_in,
  input  wire [7:0]  temperature_in,
  input  wire        carrier_toggle_in,
  input  wire [2:0]  pwm_high_in,
  input  wire [2:0]  pwm_low_in,
  output reg  [2:0]  gate_high_out,
  output reg  [2:0]  gate_low_out,
  input  wire        toggle_port_pin_in,
  output reg         toggle_port_pin_out,
  output reg         toggle_port_pin_oe_out,
  output reg         state_indicator_led_out,
  output reg         error_indicator_led_out
);

  // ***************************************************************
  // state codes
  // ***************************************************************
  localparam [1:0] ST_STOP  = 2'b00;
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_BRAKE = 2'b10;

  localparam [1:0] RED_IDLE = 2'b00;
  localparam [1:0] RED_ON   = 2'b01;
  localparam [1:0] RED_OFF  = 2'b10;
  localparam [1:0] RED_GAP  = 2'b11;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  reg  [2:0] oc_sync_r;
  reg  [2:0] zc_sync_r;
  reg  [2:0] tp_sync_r;
  reg        oc_filt_r;
  reg        zc_filt_r;
  reg        tp_filt_r;
  reg        zc_prev_r;

  // three stages; a change counts only once stages two and three agree
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      oc_sync_r <= 3'b000;
      zc_sync_r <= 3'b000;
      tp_sync_r <= 3'b000;
      oc_filt_r <= 1'b0;
      zc_filt_r <= 1'b0;
      tp_filt_r <= 1'b0;
      zc_prev_r <= 1'b0;
    end
    else
    begin
      oc_sync_r <= {oc_sync_r[1:0], overcurrent_in};
      zc_sync_r <= {zc_sync_r[1:0], zero_cross_in};
      tp_sync_r <= {tp_sync_r[1:0], toggle_port_pin_in};
      if (oc_sync_r[1] == oc_sync_r[2])
        oc_filt_r <= oc_sync_r[2];
      if (zc_sync_r[1] == zc_sync_r[2])
        zc_filt_r <= zc_sync_r[2];
      if (tp_sync_r[1] == tp_sync_r[2])
        tp_filt_r <= tp_sync_r[2];
      zc_prev_r <= zc_filt_r;
    end
  end

  wire zc_event = zc_filt_r ^ zc_prev_r;

  // ***************************************************************
  // registers and bus
  // ***************************************************************
  reg  [1:0]  state_r;
  reg  [3:0]  err_r;
  reg         tog_out_r;
  reg         cut_hi_r;
  reg         cut_lo_r;
  reg  [5:0]  irq_stat_r;
  reg  [5:0]  irq_mask_r;
  reg  [9:0]  ov_lim_r;
  reg  [9:0]  uv_lim_r;
  reg  [7:0]  temp_lim_r;
  reg  [15:0] to_lim_r;
  reg         cutoff_r;
  reg         low_volt_r;
  reg  [5:0]  irq_set;
  reg  [3:0]  err_set;
  reg  [31:0] rdata_nxt;

  wire wr_ctrl = reg_write_in && (reg_addr_in == `REG_CTRL);
  wire cmd_start   = wr_ctrl && reg_wdata_in[`CTRL_START];
  wire cmd_stop    = wr_ctrl && reg_wdata_in[`CTRL_STOP];
  wire cmd_restart = wr_ctrl && reg_wdata_in[`CTRL_RESTART];
  wire rd_irq = reg_read_in && (reg_addr_in == `REG_IRQ_STAT);

  // configuration writes; command bits are pulses and are not stored
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tog_out_r  <= 1'b0;
      cut_hi_r   <= 1'b0;
      cut_lo_r   <= 1'b0;
      irq_mask_r <= 6'h00;
      ov_lim_r   <= `OV_LIMIT_RST;
      uv_lim_r   <= `UV_LIMIT_RST;
      temp_lim_r <= `TEMP_LIMIT_RST;
      to_lim_r   <= `TO_LIMIT_RST;
    end
    else if (reg_write_in)
    begin
      case (reg_addr_in)
        `REG_CTRL:
        begin
          tog_out_r <= reg_wdata_in[`CTRL_TOG_OUT];
          cut_hi_r  <= reg_wdata_in[`CTRL_CUT_HI];
          cut_lo_r  <= reg_wdata_in[`CTRL_CUT_LO];
        end
        `REG_IRQ_MASK:   irq_mask_r <= reg_wdata_in[5:0];
        `REG_OV_LIMIT:   ov_lim_r   <= reg_wdata_in[9:0];
        `REG_UV_LIMIT:   uv_lim_r   <= reg_wdata_in[9:0];
        `REG_TEMP_LIMIT: temp_lim_r <= reg_wdata_in[7:0];
        `REG_TO_LIMIT:   to_lim_r   <= reg_wdata_in[15:0];
        default:         tog_out_r  <= tog_out_r;
      endcase
    end
  end

  // read mux; unmapped addresses read as zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr_in)
      `REG_CTRL:       rdata_nxt = {26'h0, cut_lo_r, cut_hi_r, tog_out_r,
                                    3'b000};
      `REG_STATUS:     rdata_nxt = {23'h0, tp_filt_r, low_volt_r, err_r,
                                    cutoff_r, state_r};
      `REG_IRQ_STAT:   rdata_nxt = {26'h0, irq_stat_r};
      `REG_IRQ_MASK:   rdata_nxt = {26'h0, irq_mask_r};
      `REG_OV_LIMIT:   rdata_nxt = {22'h0, ov_lim_r};
      `REG_UV_LIMIT:   rdata_nxt = {22'h0, uv_lim_r};
      `REG_TEMP_LIMIT: rdata_nxt = {24'h0, temp_lim_r};
      `REG_TO_LIMIT:   rdata_nxt = {16'h0, to_lim_r};
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_read_in)
      reg_rdata_out <= rdata_nxt;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // ***************************************************************
  // overcurrent cut-off
  // ***************************************************************
  reg  carrier_prev_r;
  wire carrier_edge = carrier_toggle_in ^ carrier_prev_r;

  // cut-off holds until the comparator is low at a peak or valley
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      carrier_prev_r <= 1'b0;
      cutoff_r       <= 1'b0;
    end
    else
    begin
      carrier_prev_r <= carrier_toggle_in;
      if (oc_filt_r)
        cutoff_r <= 1'b1;
      else if (carrier_edge)
        cutoff_r <= 1'b0;
    end
  end

  // ***************************************************************
  // monitoring and errors
  // ***************************************************************
  reg  [31:0] mon_cnt_r;
  reg  [15:0] to_cnt_r;
  wire        mon_tick = (mon_cnt_r == MON_PERIOD_CYC - 1);

  // monitor period timer and zero-crossing timeout counter
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mon_cnt_r <= 32'h0000_0000;
      to_cnt_r  <= 16'h0000;
    end
    else
    begin
      mon_cnt_r <= mon_tick ? 32'h0000_0000 : mon_cnt_r + 32'h0000_0001;
      if (state_r != ST_RUN || zc_event)
        to_cnt_r <= 16'h0000;
      else if (mon_tick && to_cnt_r != 16'hFFFF)
        to_cnt_r <= to_cnt_r + 16'h0001;
    end
  end

  // undervoltage and timeout only count as errors while driving
  always @*
  begin
    err_set = 4'h0;
    if (mon_tick && bus_voltage_in > ov_lim_r)
      err_set[`ERR_OV] = 1'b1;
    if (mon_tick && state_r == ST_RUN && bus_voltage_in < uv_lim_r)
      err_set[`ERR_UV] = 1'b1;
    if (mon_tick && state_r == ST_RUN && to_cnt_r >= to_lim_r)
      err_set[`ERR_TO] = 1'b1;
    if ($signed(temperature_in) > $signed(temp_lim_r))
      err_set[`ERR_TEMP] = 1'b1;
  end

  // ***************************************************************
  // system state machine
  // ***************************************************************
  reg  [31:0] brake_cnt_r;

  // any stop passes through the braking short before settling
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r     <= ST_STOP;
      err_r       <= 4'h0;
      brake_cnt_r <= 32'h0000_0000;
      low_volt_r  <= 1'b0;
    end
    else
    begin
      if (mon_tick)
        low_volt_r <= (bus_voltage_in < uv_lim_r);
      // a new error in the restart cycle still latches
      err_r <= (cmd_restart ? 4'h0 : err_r) | err_set;
      case (state_r)
        ST_RUN:
        begin
          if (|err_set || cmd_stop)
          begin
            state_r     <= ST_BRAKE;
            brake_cnt_r <= 32'h0000_0000;
          end
        end
        ST_BRAKE:
        begin
          brake_cnt_r <= brake_cnt_r + 32'h0000_0001;
          if (brake_cnt_r == BRAKE_CYC - 1)
            state_r <= ST_STOP;
        end
        ST_STOP:
        begin
          // start is refused while an error stays latched
          if (cmd_start && err_r == 4'h0 && err_set == 4'h0)
            state_r <= ST_RUN;
        end
        default: state_r <= ST_STOP;
      endcase
    end
  end

  // ***************************************************************
  // gate outputs and toggle pin
  // ***************************************************************
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gate_high_out          <= 3'b000;
      gate_low_out           <= 3'b000;
      toggle_port_pin_out    <= 1'b0;
      toggle_port_pin_oe_out <= 1'b0;
    end
    else
    begin
      toggle_port_pin_out    <= carrier_toggle_in;
      toggle_port_pin_oe_out <= tog_out_r;
      if (state_r == ST_BRAKE)
      begin
        gate_high_out <= 3'b000;
        gate_low_out  <= 3'b111;
      end
      else if (state_r != ST_RUN || |err_set)
      begin
        gate_high_out <= 3'b000;
        gate_low_out  <= 3'b000;
      end
      else if (oc_filt_r || cutoff_r)
      begin
        gate_high_out <= {3{cut_hi_r}};
        gate_low_out  <= {3{cut_lo_r}};
      end
      else
      begin
        gate_high_out <= pwm_high_in;
        gate_low_out  <= pwm_low_in;
      end
    end
  end

  // ***************************************************************
  // interrupts
  // ***************************************************************
  reg cutoff_prev_r;

  always @*
  begin
    irq_set = {2'b00, err_set & ~err_r};
    irq_set[`IRQ_CUTOFF]  = cutoff_r & ~cutoff_prev_r;
    irq_set[`IRQ_STOPPED] = (state_r == ST_BRAKE) &&
                            (brake_cnt_r == BRAKE_CYC - 1);
  end

  // sticky status, cleared by reading it; a set in that cycle wins
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cutoff_prev_r <= 1'b0;
      irq_stat_r    <= 6'h00;
      irq_out       <= 1'b0;
    end
    else
    begin
      cutoff_prev_r <= cutoff_r;
      irq_stat_r    <= (rd_irq ? 6'h00 : irq_stat_r) | irq_set;
      irq_out       <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ***************************************************************
  // status lamps
  // ***************************************************************
  reg  [31:0] led_cnt_r;
  reg  [3:0]  grn_cnt_r;
  reg  [3:0]  red_tk_r;
  reg  [3:0]  red_left_r;
  reg  [1:0]  red_st_r;
  wire        led_tick = (led_cnt_r == LED_TICK_CYC - 1);
  wire [3:0]  grn_half = low_volt_r ? `GREEN_SLOW_TK : `GREEN_FAST_TK;

  // green: steady in a clean stop, 1 s blink on low supply, 0.4 s running
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      led_cnt_r               <= 32'h0000_0000;
      grn_cnt_r               <= 4'h0;
      state_indicator_led_out <= 1'b0;
    end
    else
    begin
      led_cnt_r <= led_tick ? 32'h0000_0000 : led_cnt_r + 32'h0000_0001;
      if (err_r != 4'h0)
        state_indicator_led_out <= 1'b0;
      else if (state_r == ST_STOP && !low_volt_r)
        state_indicator_led_out <= 1'b1;
      else if (led_tick)
      begin
        if (grn_cnt_r >= grn_half - 4'h1)
        begin
          grn_cnt_r               <= 4'h0;
          state_indicator_led_out <= ~state_indicator_led_out;
        end
        else
          grn_cnt_r <= grn_cnt_r + 4'h1;
      end
    end
  end

  // red: bursts of err_r flashes, then a pause; the code is resampled
  // at each burst so a later error shows from the next burst on
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      red_st_r                <= RED_IDLE;
      red_tk_r                <= 4'h0;
      red_left_r              <= 4'h0;
      error_indicator_led_out <= 1'b0;
    end
    else
    begin
      case (red_st_r)
        RED_IDLE:
        begin
          error_indicator_led_out <= 1'b0;
          if (err_r != 4'h0 && led_tick)
          begin
            red_left_r              <= err_r;
            red_tk_r                <= 4'h0;
            red_st_r                <= RED_ON;
            error_indicator_led_out <= 1'b1;
          end
        end
        RED_ON:
        begin
          if (led_tick)
          begin
            if (red_tk_r == `RED_HALF_TK - 1)
            begin
              red_tk_r                <= 4'h0;
              red_left_r              <= red_left_r - 4'h1;
              error_indicator_led_out <= 1'b0;
              red_st_r                <= RED_OFF;
            end
            else
              red_tk_r <= red_tk_r + 4'h1;
          end
        end
        RED_OFF:
        begin
          if (led_tick)
          begin
            if (red_tk_r == `RED_HALF_TK - 1)
            begin
              red_tk_r <= 4'h0;
              if (red_left_r == 4'h0)
                red_st_r <= RED_GAP;
              else
              begin
                error_indicator_led_out <= 1'b1;
                red_st_r                <= RED_ON;
              end
            end
            else
              red_tk_r <= red_tk_r + 4'h1;
          end
        end
        default:
        begin
          error_indicator_led_out <= 1'b0;
          if (led_tick)
          begin
            if (red_tk_r == `RED_GAP_TK - 1)
            begin
              red_tk_r <= 4'h0;
              red_st_r <= RED_IDLE;
            end
            else
              red_tk_r <= red_tk_r + 4'h1;
          end
        end
      endcase
    end
  end

endmodule // motor_protection_supervisor

// *** testbench/inverter_bridge_model.sv ***
// inverter bridge model: shunt comparator and back-emf crossings
module inverter_bridge_model
(
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  input  wire logic [2:0] gate_high_in,
  input  wire logic [2:0] gate_low_in,
  input  wire logic       oc_cmd_in,
  input  wire logic       zc_en_in,
  output wire logic       overcurrent_out,
  output logic            zero_cross_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] div_r;

  // a leg with both switches on is a short, so the shunt sees overcurrent
  assign overcurrent_out = oc_cmd_in | (|(gate_high_in & gate_low_in));

  // one crossing edge every 16 cycles; a stalled rotor gives none
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_r          <= 4'h0;
      zero_cross_out <= 1'b0;
    end
    else if (zc_en_in)
    begin
      div_r <= div_r + 4'h1;
      if (div_r == 4'hF)
        zero_cross_out <= ~zero_cross_out;
    end
  end
endmodule // inverter_bridge_model

// *** testbench/motor_protection_properties.sv ***
// checker of cut-off, braking, toggle pin and lamp relations
module motor_protection_checker
#(
  parameter LED_TICK_CYC   = 10,
  parameter MON_PERIOD_CYC = 8,
  parameter BRAKE_CYC      = 16
)
(
  input wire logic        clock_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        irq_out,
  input wire logic        overcurrent_in,
  input wire logic        zero_cross_in,
  input wire logic [9:0]  bus_voltage_in,
  input wire logic [7:0]  temperature_in,
  input wire logic        carrier_toggle_in,
  input wire logic [2:0]  pwm_high_in,
  input wire logic [2:0]  pwm_low_in,
  input wire logic [2:0]  gate_high_out,
  input wire logic [2:0]  gate_low_out,
  input wire logic        toggle_port_pin_in,
  input wire logic        toggle_port_pin_out,
  input wire logic        toggle_port_pin_oe_out,
  input wire logic        state_indicator_led_out,
  input wire logic        error_indicator_led_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  // *****
  // cut-off steps: comparator held high, then quiet carrier
  // *****
  sequence s_cut;
    overcurrent_in [*6];
  endsequence
  sequence s_quiet;
    (!overcurrent_in && $stable(carrier_toggle_in)) [*8];
  endsequence

  a_cut_high_off: assert property (s_cut |=> gate_high_out == 3'h0)
    else $error("high side on during cut-off");
  a_cut_low_off: assert property
    (s_cut |=> gate_low_out == 3'h0 || gate_low_out == 3'h7)
    else $error("low side on during cut-off");
  // no carrier edge means no release, checked after 8 cycles of low current
  a_release_wait: assert property
    (s_cut ##1 s_quiet |-> gate_high_out == 3'h0)
    else $error("cut-off released without carrier edge");
  a_brake_hold: assert property ($rose(gate_low_out == 3'h7) |->
    (gate_low_out == 3'h7 && gate_high_out == 3'h0) [*8])
    else $error("braking too short");
  a_toggle_copy: assert property
    ($past(arst_n_in) && toggle_port_pin_oe_out |->
     toggle_port_pin_out == $past(carrier_toggle_in))
    else $error("toggle pin does not follow carrier");
  a_red_flash: assert property
    ($rose(error_indicator_led_out) |-> error_indicator_led_out [*8])
    else $error("red flash too short");
  a_lamp_split: assert property
    (error_indicator_led_out |-> !state_indicator_led_out)
    else $error("green lit with error latched");
  a_read_idle: assert property
    (!$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule // motor_protection_checker

bind motor_protection_supervisor motor_protection_checker #(
  .LED_TICK_CYC(LED_TICK_CYC), .MON_PERIOD_CYC(MON_PERIOD_CYC),
  .BRAKE_CYC(BRAKE_CYC)) chk_u (
  .clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .irq_out(irq_out), .overcurrent_in(overcurrent_in),
  .zero_cross_in(zero_cross_in), .bus_voltage_in(bus_voltage_in),
  .temperature_in(temperature_in), .carrier_toggle_in(carrier_toggle_in),
  .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in),
  .gate_high_out(gate_high_out), .gate_low_out(gate_low_out),
  .toggle_port_pin_in(toggle_port_pin_in),
  .toggle_port_pin_out(toggle_port_pin_out),
  .toggle_port_pin_oe_out(toggle_port_pin_oe_out),
  .state_indicator_led_out(state_indicator_led_out),
  .error_indicator_led_out(error_indicator_led_out));

// *** testbench/test_motor_protection_supervisor.sv ***
// self-checking bench of the protection supervisor
module test_motor_protection_supervisor;
  timeunit 1ns;
  timeprecision 1ps;

  localparam TICK = 10;
  logic        clock_in, arst_n_in, reg_write_in, reg_read_in, carrier;
  logic [7:0]  reg_addr_in, temp;
  logic [31:0] reg_wdata_in, rdata, rd_d;
  logic [9:0]  bus;
  logic [2:0]  gh, gl;
  logic        irq, oc, zc, oc_cmd, zc_en, pin_out, pin_oe, green, red;
  wire logic   pin_in = pin_oe ? pin_out : 1'b1;  // pulled up when idle
  int          err_total = 0;
  int          checks = 0;
  int          cycles = 0;

  motor_protection_supervisor #(.LED_TICK_CYC(TICK), .MON_PERIOD_CYC(8),
    .BRAKE_CYC(16)) dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(rdata), .irq_out(irq), .overcurrent_in(oc),
    .zero_cross_in(zc), .bus_voltage_in(bus), .temperature_in(temp),
    .carrier_toggle_in(carrier), .pwm_high_in(3'h1), .pwm_low_in(3'h2),
    .gate_high_out(gh), .gate_low_out(gl), .toggle_port_pin_in(pin_in),
    .toggle_port_pin_out(pin_out), .toggle_port_pin_oe_out(pin_oe),
    .state_indicator_led_out(green), .error_indicator_led_out(red));
  inverter_bridge_model br_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .gate_high_in(gh), .gate_low_in(gl), .oc_cmd_in(oc_cmd),
    .zc_en_in(zc_en), .overcurrent_out(oc), .zero_cross_out(zc));

  // *****
  // bus cycles and measurement helpers
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  task automatic flip;
    @(posedge clock_in);
    carrier <= ~carrier;
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? green : s == 1 ? red : gl == 3'h7;
  endfunction
  // cycles until the picked level changes, cut at lim
  task automatic run_len(input int s, input int lim, output int n);
    logic v;
    v = pick(s);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (pick(s) === v && n < lim);
  endtask

  // *****
  // scenarios
  // *****
  task automatic t_reset;
    chk(32'(green), 32'h0000_0001);
    rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0118);
    rdchk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(8'h04, 32'hFFFF_FFFF, 32'h0000_0100);
  endtask
  task automatic t_cutoff;
    int n;
    wr(8'h00, 32'h0000_0009);
    rdchk(8'h04, 32'h0000_0003, 32'h0000_0001);
    chk(32'({gh, gl}), 32'h0000_000A);
    run_len(0, 100, n);
    run_len(0, 100, n);
    chk(n, 2 * TICK);
    flip();
    cyc(2);
    chk(32'({pin_oe, pin_out}), 32'({1'b1, carrier}));
    wr(8'h0C, 32'h0000_0010);
    @(posedge clock_in);
    oc_cmd <= 1'b1;
    cyc(8);
    chk(32'({gh, gl}), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0004, 32'h0000_0004);
    @(posedge clock_in);
    oc_cmd <= 1'b0;
    cyc(12);
    chk(32'({gh, gl}), 32'h0000_0000);
    flip();
    cyc(3);
    chk(32'({gh, gl}), 32'h0000_000A);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h0000_0010);
    cyc(2);
    chk(32'(irq), 32'h0000_0000);
  endtask
  task automatic t_stop;
    int n;
    wr(8'h00, 32'h0000_0002);
    run_len(2, 8, n);
    run_len(2, 40, n);
    chk(n, 16);
    rdchk(8'h04, 32'h0000_0003, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0020, 32'h0000_0020);
    @(posedge clock_in);
    bus <= 10'h095;
    run_len(0, 200, n);
    run_len(0, 200, n);
    chk(n, 5 * TICK);
  endtask
  // error in run: brake, latch, red burst of 1 << code flashes
  task automatic t_err(input int code);
    int n, k, cnt;
    @(posedge clock_in);
    bus   <= 10'h0FA;
    temp  <= 8'h19;
    zc_en <= 1'b1;
    wr(8'h00, 32'h0000_0004);
    wr(8'h00, 32'h0000_0001);
    cyc(4);
    @(posedge clock_in);
    case (code)
      0: bus <= 10'h119;
      1: bus <= 10'h095;
      2: zc_en <= 1'b0;
      default: temp <= 8'h42;
    endcase
    run_len(2, 600, n);
    chk(32'(gl), 32'h0000_0007);
    k = 0;
    do
    begin
      run_len(1, 300, n);
      k++;
    end
    while (!(n >= 30 && red === 1'b1) && k < 40);
    cnt = 0;
    do
    begin
      run_len(1, 30, n);
      chk(n, 2 * TICK);
      cnt++;
      run_len(1, 30, n);
    end
    while (n == 2 * TICK && cnt < 9);
    chk(cnt, 32'h1 << code);
    chk(32'(green), 32'h0000_0000);
    rdchk(8'h04, 32'h0000_007B, 32'h1 << (code + 3));
    chk(32'({gh, gl}), 32'h0000_0000);
  endtask

  task automatic conclude;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // free-running clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // a hang counts as a mismatch
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    arst_n_in    = 1'b0;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_write_in = 1'b0;
    reg_read_in  = 1'b0;
    bus          = 10'h0FA;
    temp         = 8'h19;
    carrier      = 1'b0;
    oc_cmd       = 1'b0;
    zc_en        = 1'b1;
    repeat (16) @(posedge clock_in);
    arst_n_in <= 1'b1;
    cyc(2);
    t_reset();
    t_cutoff();
    t_stop();
    wr(8'h1C, 32'h0000_0004);
    for (int c = 0; c < 4; c++)
      t_err(c);
    conclude();
  end
endmodule // test_motor_protection_supervisor
